// ==== hdl/pepc_port_e.sv ====
`timescale 1ns/100ps
module pepc_port_e (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Programming state
  input wire logic hv_prog_mode_i,
  // Pins 0 to 2
  input wire logic [2:0] port_e_pins_pin_i,
  output logic [2:0] port_e_pins_pin_o,
  output logic [2:0] port_e_pins_pin_oe_b_o,
  // Pin 3 and its pull-up
  input wire logic port_e_pins_pin3_input_i,
  output logic pin3_pullup_on_o,
  output logic master_clear_n_o,
  // Port B pull-ups
  input wire logic [7:0] portb_pullup_enable_i,
  output logic [7:0] portb_pullup_on_o,
  // Peripheral outputs
  input wire logic pwm3_output_a_i,
  input wire logic pwm3_output_b_i,
  input wire logic capcomp3_signal_i,
  input wire logic capcomp5_signal_i,
  // Peripheral inputs
  output logic capcomp3_capture_o,
  output logic capcomp5_capture_o,
  output logic [2:0] analog_input_active_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Register access decode

  logic setup_ph;
  logic access_ph;
  logic [3:0] idx;
  logic idx_ok;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] file_rd;
  logic [8*pepc_pkg::NUM_REGS-1:0] regs;
  logic [7:0] latch_e;
  logic [7:0] direction_e;
  logic [7:0] analog_select_e;
  logic [7:0] interrupt_control_two;
  logic [7:0] config_word_three_high;
  logic [7:0] config_word_four_low;
  logic [7:0] periph_en;
  logic [7:0] port_e_pins;
  logic rd_port;
  logic rd_valid;

  function automatic logic [3:0] addr_to_idx(input logic [11:0] addr);
    addr_to_idx = addr[5:2];
  endfunction

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign idx = addr_to_idx(paddr);
  assign idx_ok = (paddr[1:0] == 2'h0) && (paddr[11:6] == 6'h00) &&
                  (idx < 4'(pepc_pkg::NUM_REGS));

  // Read data registered in setup, so every access completes in one wait-free cycle
  assign pready = access_ph;
  assign pslverr = access_ph && !idx_ok;

  always_comb begin
    wr_data = pwdata[7:0];
    wr_en = 1'b0;
    if (access_ph && pwrite && idx_ok) begin
      unique case (paddr)
        pepc_pkg::ADDR_PORT: begin
          wr_en = 1'b0;
        end
        pepc_pkg::ADDR_CFG4L: begin
          wr_en = 1'b1;
          // LOW_VOLTAGE_PROG_ENABLE bit only moves in high-voltage programming mode
          if (!hv_prog_mode_i) begin
            wr_data[pepc_pkg::CFG4L_LVP_BIT] =
              config_word_four_low[pepc_pkg::CFG4L_LVP_BIT];
          end
        end
        default: begin
          wr_en = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic port_wr;
  logic [3:0] file_idx;

  // A port write lands in the latch register
  assign port_wr = access_ph && pwrite && (paddr == pepc_pkg::ADDR_PORT);
  assign file_idx = port_wr ? 4'h1 : idx;

  pepc_regfile u_regfile (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(wr_en || port_wr),
    .wr_idx_i(file_idx),
    .wr_data_i(wr_data),
    .rd_idx_i(idx),
    .rd_data_o(file_rd),
    .regs_o(regs)
  );

  assign latch_e = regs[8*1 +: 8];
  assign direction_e = regs[8*2 +: 8];
  assign analog_select_e = regs[8*3 +: 8];
  assign interrupt_control_two = regs[8*4 +: 8];
  assign config_word_three_high = regs[8*6 +: 8];
  assign config_word_four_low = regs[8*7 +: 8];
  assign periph_en = regs[8*8 +: 8];

  ////////////////////////////////////////////////////////////////////////////////
  // Pin control

  logic master_clear_enable;
  logic small_pkg;
  logic capcomp3_pin_map;
  logic global_pullup_disable_n;
  logic pin3_pullup_enable;
  logic [2:0] out_val;
  logic [2:0] out_en;

  assign master_clear_enable = config_word_three_high[pepc_pkg::CFG3H_MASTER_CLEAR_N_EN_BIT];
  assign capcomp3_pin_map = config_word_three_high[pepc_pkg::CFG3H_CAPCOMP3_SIGNAL_MAP_BIT];
  assign small_pkg = periph_en[pepc_pkg::PER_SMALL_PKG];
  assign global_pullup_disable_n = interrupt_control_two[pepc_pkg::INTERRUPT_CONTROL_TWO_PULLUP_DIS_BIT];
  assign pin3_pullup_enable = direction_e[pepc_pkg::DIR_PULLUP_BIT];

  // Priority falls in listed order; analog select does not block outputs
  always_comb begin
    out_val = latch_e[2:0];
    out_en = ~direction_e[2:0];
    if (!capcomp3_pin_map && periph_en[pepc_pkg::PER_PWM3A_EN]) begin
      out_val[0] = pwm3_output_a_i;
    end else if (!capcomp3_pin_map && periph_en[pepc_pkg::PER_CAPCOMP3_SIGNAL_EN]) begin
      out_val[0] = capcomp3_signal_i;
    end
    if (periph_en[pepc_pkg::PER_PWM3B_EN]) begin
      out_val[1] = pwm3_output_b_i;
    end
    if (periph_en[pepc_pkg::PER_CAPCOMP5_SIGNAL_EN]) begin
      out_val[2] = capcomp5_signal_i;
    end
    // Small package bonds out no pins 0 to 2
    if (small_pkg) begin
      out_en = 3'h0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_e_pins_pin_o <= 3'h0;
      port_e_pins_pin_oe_b_o <= 3'h7;
    end else begin
      port_e_pins_pin_o <= out_val;
      port_e_pins_pin_oe_b_o <= ~out_en;
    end
  end

  // Pull-ups: global disable wins, pin 3 only as a port input
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin3_pullup_on_o <= 1'b0;
      portb_pullup_on_o <= 8'h00;
    end else begin
      pin3_pullup_on_o <= !global_pullup_disable_n && pin3_pullup_enable &&
                          !master_clear_enable;
      portb_pullup_on_o <= global_pullup_disable_n ? 8'h00 :
                           portb_pullup_enable_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      master_clear_n_o <= 1'b1;
    end else begin
      master_clear_n_o <= master_clear_enable ? port_e_pins_pin3_input_i : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input path

  logic [2:0] dig_in;

  // Analog pins read 0; a driven pin reads its own level back
  assign dig_in = port_e_pins_pin_i & ~analog_select_e[2:0] & {3{!small_pkg}};

  always_comb begin
    port_e_pins = 8'h00;
    port_e_pins[2:0] = dig_in;
    port_e_pins[pepc_pkg::PORT_PIN3_BIT] = !master_clear_enable && port_e_pins_pin3_input_i;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      capcomp3_capture_o <= 1'b0;
      capcomp5_capture_o <= 1'b0;
      analog_input_active_o <= 3'h0;
    end else begin
      capcomp3_capture_o <= direction_e[0] && !capcomp3_pin_map && dig_in[0];
      capcomp5_capture_o <= direction_e[2] && dig_in[2];
      analog_input_active_o <= analog_select_e[2:0] & {3{!small_pkg}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  assign rd_port = setup_ph && (paddr == pepc_pkg::ADDR_PORT);
  assign rd_valid = setup_ph && idx_ok;

  logic [7:0] port_snap;
  logic port_sel;

  // Port level is sampled in setup so it matches the cycle software asked
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_snap <= 8'h00;
      port_sel <= 1'b0;
    end else if (setup_ph) begin
      port_snap <= port_e_pins;
      port_sel <= rd_port;
    end
  end

  logic rd_ok_q;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ok_q <= 1'b0;
    end else if (setup_ph) begin
      rd_ok_q <= rd_valid;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (access_ph && !pwrite && rd_ok_q) begin
      prdata[7:0] = port_sel ? port_snap : file_rd;
    end
  end
endmodule

// ==== hdl/pepc_pkg.sv ====
package pepc_pkg;
  localparam logic [11:0] ADDR_PORT = 12'h000;
  localparam logic [11:0] ADDR_LATCH = 12'h004;
  localparam logic [11:0] ADDR_DIR = 12'h008;
  localparam logic [11:0] ADDR_ANSEL = 12'h00C;
  localparam logic [11:0] ADDR_INTERRUPT_CONTROL_TWO = 12'h010;
  localparam logic [11:0] ADDR_SLEW = 12'h014;
  localparam logic [11:0] ADDR_CFG3H = 12'h018;
  localparam logic [11:0] ADDR_CFG4L = 12'h01C;
  localparam logic [11:0] ADDR_PERIPH = 12'h020;
  localparam int unsigned NUM_REGS = 9;

  localparam int unsigned DIR_PULLUP_BIT = 7;
  localparam int unsigned INTERRUPT_CONTROL_TWO_PULLUP_DIS_BIT = 7;
  localparam int unsigned CFG3H_MASTER_CLEAR_N_EN_BIT = 7;
  localparam int unsigned CFG3H_CAPCOMP3_SIGNAL_MAP_BIT = 2;
  localparam int unsigned CFG4L_LVP_BIT = 2;
  localparam int unsigned PORT_PIN3_BIT = 3;

  localparam logic [7:0] DIR_MASK = 8'h87;
  localparam logic [7:0] LATCH_MASK = 8'h07;
  localparam logic [7:0] ANSEL_MASK = 8'h07;
  localparam logic [7:0] INTERRUPT_CONTROL_TWO_MASK = 8'hF5;
  localparam logic [7:0] SLEW_MASK = 8'h1F;
  localparam logic [7:0] CFG3H_MASK = 8'hBF;
  localparam logic [7:0] CFG4L_MASK = 8'hC5;
  localparam logic [7:0] PERIPH_MASK = 8'h1F;

  localparam logic [7:0] DIR_RESET = 8'h07;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] ANSEL_RESET = 8'h07;
  localparam logic [7:0] INTERRUPT_CONTROL_TWO_RESET = 8'hF5;
  localparam logic [7:0] SLEW_RESET = 8'h1F;
  localparam logic [7:0] CFG3H_RESET = 8'hBF;
  localparam logic [7:0] CFG4L_RESET = 8'h85;
  localparam logic [7:0] PERIPH_RESET = 8'h00;

  // Peripheral enable register fields
  localparam int unsigned PER_PWM3A_EN = 0;
  localparam int unsigned PER_PWM3B_EN = 1;
  localparam int unsigned PER_CAPCOMP3_SIGNAL_EN = 2;
  localparam int unsigned PER_CAPCOMP5_SIGNAL_EN = 3;
  localparam int unsigned PER_SMALL_PKG = 4;
endpackage

// ==== hdl/pepc_regfile.sv ====
`timescale 1ns/100ps
module pepc_regfile (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  // Read port
  input wire logic [3:0] rd_idx_i,
  output logic [7:0] rd_data_o,
  // Flat view of all stored registers
  output logic [8*pepc_pkg::NUM_REGS-1:0] regs_o
);
  logic [7:0] mem [pepc_pkg::NUM_REGS];

  function automatic logic [7:0] mask_of(input logic [3:0] idx);
    case (idx)
      4'h1: mask_of = pepc_pkg::LATCH_MASK;
      4'h2: mask_of = pepc_pkg::DIR_MASK;
      4'h3: mask_of = pepc_pkg::ANSEL_MASK;
      4'h4: mask_of = pepc_pkg::INTERRUPT_CONTROL_TWO_MASK;
      4'h5: mask_of = pepc_pkg::SLEW_MASK;
      4'h6: mask_of = pepc_pkg::CFG3H_MASK;
      4'h7: mask_of = pepc_pkg::CFG4L_MASK;
      4'h8: mask_of = pepc_pkg::PERIPH_MASK;
      default: mask_of = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] reset_of(input int idx);
    case (idx)
      1: reset_of = pepc_pkg::LATCH_RESET;
      2: reset_of = pepc_pkg::DIR_RESET;
      3: reset_of = pepc_pkg::ANSEL_RESET;
      4: reset_of = pepc_pkg::INTERRUPT_CONTROL_TWO_RESET;
      5: reset_of = pepc_pkg::SLEW_RESET;
      6: reset_of = pepc_pkg::CFG3H_RESET;
      7: reset_of = pepc_pkg::CFG4L_RESET;
      8: reset_of = pepc_pkg::PERIPH_RESET;
      default: reset_of = 8'h00;
    endcase
  endfunction

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < pepc_pkg::NUM_REGS; i++) begin
        mem[i] <= reset_of(i);
      end
    end else if (wr_en_i && (wr_idx_i < 4'(pepc_pkg::NUM_REGS))) begin
      mem[wr_idx_i] <= wr_data_i & mask_of(wr_idx_i);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_idx_i < 4'(pepc_pkg::NUM_REGS)) begin
      rd_data_o <= mem[rd_idx_i];
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  always_comb begin
    for (int i = 0; i < pepc_pkg::NUM_REGS; i++) begin
      regs_o[8*i +: 8] = mem[i];
    end
  end
endmodule

// ==== verif/pepc_tb_tables.svh ====
// Register map seen by the bench and the checker; index 0 is the port view
localparam logic [11:0] AD [9] = '{pepc_pkg::ADDR_PORT, pepc_pkg::ADDR_LATCH,
  pepc_pkg::ADDR_DIR, pepc_pkg::ADDR_ANSEL, pepc_pkg::ADDR_INTERRUPT_CONTROL_TWO, pepc_pkg::ADDR_SLEW,
  pepc_pkg::ADDR_CFG3H, pepc_pkg::ADDR_CFG4L, pepc_pkg::ADDR_PERIPH};
localparam logic [7:0] MSK [9] = '{pepc_pkg::LATCH_MASK, pepc_pkg::LATCH_MASK,
  pepc_pkg::DIR_MASK, pepc_pkg::ANSEL_MASK, pepc_pkg::INTERRUPT_CONTROL_TWO_MASK, pepc_pkg::SLEW_MASK,
  pepc_pkg::CFG3H_MASK, pepc_pkg::CFG4L_MASK, pepc_pkg::PERIPH_MASK};
localparam logic [7:0] RST [9] = '{8'h00, pepc_pkg::LATCH_RESET,
  pepc_pkg::DIR_RESET, pepc_pkg::ANSEL_RESET, pepc_pkg::INTERRUPT_CONTROL_TWO_RESET, pepc_pkg::SLEW_RESET,
  pepc_pkg::CFG3H_RESET, pepc_pkg::CFG4L_RESET, pepc_pkg::PERIPH_RESET};

// ==== verif/pepc_board.sv ====
`timescale 1ns/100ps
module pepc_board (
  // Clock
  input wire logic ref_clk_i,
  // Device side
  input wire logic [2:0] pin_o_i,
  input wire logic [2:0] oe_b_i,
  input wire logic pull3_i,
  // Board drive
  input wire logic [2:0] ext_i,
  input wire logic ext3_en_i,
  input wire logic ext3_i,
  // Pin levels
  output logic [2:0] pin_o,
  output logic pin3_o
);
  logic tog = 1'h0;
  always_ff @(posedge ref_clk_i) begin
    tog <= !tog;
  end
  // A driving device pin wins over the board's own drive
  assign pin_o = (pin_o_i & ~oe_b_i) | (ext_i & oe_b_i);
  // A floating pin 3 wanders unless the weak pull-up holds it
  assign pin3_o = ext3_en_i ? ext3_i : (pull3_i | tog);
endmodule

// ==== verif/pepc_port_e_assertions.sv ====
`timescale 1ns/100ps
module pepc_chk (
  // Clock, reset and bus
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic hv_prog_mode_i,
  // Pins and peripherals
  input wire logic [2:0] port_e_pins_pin_i,
  input wire logic [2:0] port_e_pins_pin_o,
  input wire logic [2:0] port_e_pins_pin_oe_b_o,
  input wire logic port_e_pins_pin3_input_i,
  input wire logic pin3_pullup_on_o,
  input wire logic master_clear_n_o,
  input wire logic [7:0] portb_pullup_enable_i,
  input wire logic [7:0] portb_pullup_on_o,
  input wire logic pwm3_output_a_i,
  input wire logic pwm3_output_b_i,
  input wire logic capcomp3_signal_i,
  input wire logic capcomp5_signal_i,
  input wire logic [2:0] analog_input_active_o
);
  `include "pepc_tb_tables.svh"
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] sh [9];
  logic up;
  wire acc = psel & penable;
  wire [3:0] ix = paddr[5:2];
  wire ok = paddr[11:6] == 6'h00 && paddr[1:0] == 2'h0 && ix < 4'h9;
  wire [3:0] wi = (ix == 4'h0) ? 4'h1 : ix;
  wire [7:0] lk = (wi == 4'h7 && !hv_prog_mode_i) ? 8'h04 : 8'h00;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sh <= RST;
      up <= 1'h0;
    end else begin
      up <= 1'h1;
      if (acc && pwrite && ok) begin
        sh[wi] <= (pwdata[7:0] & MSK[wi] & ~lk) | (sh[wi] & lk);
      end
    end
  end
  wire pud = sh[4][7];
  wire mcl = sh[6][7];
  wire mp = sh[6][2];
  wire sm = sh[8][4];
  wire x_p3 = sh[2][7] & !pud & !mcl;
  wire [7:0] x_pb = portb_pullup_enable_i & {8{!pud}};
  wire [2:0] x_oe = sh[2][2:0] | {3{sm}};
  wire [2:0] x_an = sh[3][2:0] & ~{3{sm}};
  wire x_mc = !mcl | port_e_pins_pin3_input_i;
  wire [2:0] x_o = {sh[8][3] ? capcomp5_signal_i : sh[1][2],
    sh[8][1] ? pwm3_output_b_i : sh[1][1],
    sh[8][0] & !mp ? pwm3_output_a_i : sh[8][2] & !mp ? capcomp3_signal_i : sh[1][0]};
  wire [7:0] x_rd = {4'h0, port_e_pins_pin3_input_i & !mcl, port_e_pins_pin_i & ~sh[3][2:0] & ~{3{sm}}};
  ////////////////////////////////////////////////////////////////////////////////
  property p_pull3; up |-> pin3_pullup_on_o == $past(x_p3); endproperty
  a_pull3: assert property (p_pull3) else $error("pin 3 pull-up wrong");
  property p_pullb; up |-> portb_pullup_on_o == $past(x_pb); endproperty
  a_pullb: assert property (p_pullb) else $error("port b pull-ups wrong");
  property p_oe; up |-> port_e_pins_pin_oe_b_o == $past(x_oe); endproperty
  a_oe: assert property (p_oe) else $error("driver enable wrong");
  property p_an; up |-> analog_input_active_o == $past(x_an); endproperty
  a_an: assert property (p_an) else $error("analog input select wrong");
  property p_mc; up |-> master_clear_n_o == $past(x_mc); endproperty
  a_mc: assert property (p_mc) else $error("master clear wrong");
  property p_o; up |-> ((port_e_pins_pin_o ^ $past(x_o)) & ~port_e_pins_pin_oe_b_o) == 3'h0; endproperty
  a_o: assert property (p_o) else $error("pin drive value wrong");
  property p_rd; acc && !pwrite && ok && ix == 4'h0 |-> prdata == {24'h0, $past(x_rd)};
  endproperty
  a_rd: assert property (p_rd) else $error("port read wrong");
  property p_rb; acc && !pwrite && ok && ix != 4'h0 |-> prdata == {24'h0, sh[ix]}; endproperty
  a_rb: assert property (p_rb) else $error("register readback wrong");
  property p_bad; acc && !ok |-> pslverr && prdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped access not refused");
endmodule

bind pepc_port_e pepc_chk u_chk (.ref_clk_i, .rst_b_i, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pslverr, .hv_prog_mode_i, .port_e_pins_pin_i, .port_e_pins_pin_o, .port_e_pins_pin_oe_b_o,
  .port_e_pins_pin3_input_i, .pin3_pullup_on_o, .master_clear_n_o, .portb_pullup_enable_i,
  .portb_pullup_on_o, .pwm3_output_a_i, .pwm3_output_b_i, .capcomp3_signal_i,
  .capcomp5_signal_i, .analog_input_active_o);

// ==== verif/port_e_pin_control_test.sv ====
`timescale 1ns/100ps
module port_e_pin_control_test;
  `include "pepc_tb_tables.svh"
  logic ref_clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, hv = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, pin3, pull3, mc_n, e, h, cap3, cap5;
  logic pwa = 1'h0, pwb = 1'h0, c3 = 1'h0, c5 = 1'h0, e3 = 1'h0, e3en = 1'h1;
  logic [2:0] pin_i, pin_o, oe_b, an_o, m, ext = 3'h0;
  logic [7:0] pb_en = 8'hFF, pb_on, v, k;
  logic [7:0] sh [9];
  int error_cnt = 0, checks_done = 0;
  pepc_port_e u_dut (.ref_clk_i, .rst_b_i, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .hv_prog_mode_i(hv), .port_e_pins_pin_i(pin_i),
    .port_e_pins_pin_o(pin_o), .port_e_pins_pin_oe_b_o(oe_b), .port_e_pins_pin3_input_i(pin3),
    .pin3_pullup_on_o(pull3), .master_clear_n_o(mc_n), .portb_pullup_enable_i(pb_en),
    .portb_pullup_on_o(pb_on), .pwm3_output_a_i(pwa), .pwm3_output_b_i(pwb),
    .capcomp3_signal_i(c3), .capcomp5_signal_i(c5), .capcomp3_capture_o(cap3),
    .capcomp5_capture_o(cap5), .analog_input_active_o(an_o));
  pepc_board u_board (.ref_clk_i, .pin_o_i(pin_o), .oe_b_i(oe_b), .pull3_i(pull3),
    .ext_i(ext), .ext3_en_i(e3en), .ext3_i(e3), .pin_o(pin_i), .pin3_o(pin3));
  initial begin
    forever #5 ref_clk_i = !ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic chk_pin(input logic [7:0] g, input logic [7:0] x);
    chk_reg({24'h0, g}, {24'h0, x});
  endtask
  // Called just after an edge; one idle cycle follows each transfer
  // Waits as long as the slave needs; only the watchdog ends a hung transfer
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk_i);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk_i);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk_i);
  endtask
  function automatic logic x3();
    return sh[2][7] & !sh[4][7] & !sh[6][7];
  endfunction
  function automatic logic [2:0] exp_o();
    return {sh[8][3] ? c5 : sh[1][2], sh[8][1] ? pwb : sh[1][1],
      sh[8][0] & !sh[6][2] ? pwa : sh[8][2] & !sh[6][2] ? c3 : sh[1][0]};
  endfunction
  function automatic logic [7:0] exp_rd();
    logic [2:0] lv;
    lv = (ext & m) | (exp_o() & ~m);
    return {4'h0, !sh[6][7] & (!e3en | e3), lv & ~sh[3][2:0] & ~{3{sh[8][4]}}};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hAAA1));
    sh = RST;
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'h1;
    repeat (2) @(posedge ref_clk_i);
    chk_pin(8'(oe_b), 8'h07);
    chk_pin(8'(an_o), 8'h07);
    chk_pin(pb_on, 8'h00);
    chk_pin(8'(pull3), 8'h00);
    for (int j = 0; j < 2; j++) begin
      apb(j ? 12'h002 : 12'h024, 1'h1, 8'hFF);
      chk_pin(8'(e), 8'h01);
      apb(j ? 12'h002 : 12'h024, 1'h0, 8'h00);
      chk_reg(r, 32'h0);
    end
    for (int i = 0; i < 9; i++) begin
      apb(AD[i], 1'h0, 8'h00);
      chk_reg(r, {24'h0, RST[i]});
    end
    repeat (40) begin
      for (int i = 1; i < 9; i++) begin
        v = 8'($urandom);
        h = 1'($urandom);
        // Keep the small-package case rare so the pins get exercised
        if (i == 8) v[4] = v[4] & v[5];
        hv <= h;
        k = (i == 7 && !h) ? 8'h04 : 8'h00;
        apb((i == 1 && h) ? AD[0] : AD[i], 1'h1, v);
        sh[i] = (v & MSK[i] & ~k) | (sh[i] & k);
      end
      {ext, e3, pwa, pwb, c3, c5} <= 8'($urandom);
      pb_en <= 8'($urandom);
      e3en <= !x3() | 1'($urandom);
      repeat (2) @(posedge ref_clk_i);
      m = sh[2][2:0] | {3{sh[8][4]}};
      chk_pin(8'(oe_b), 8'(m));
      chk_pin(8'(pin_o & ~m), 8'(exp_o() & ~m));
      chk_pin(8'(pull3), 8'(x3()));
      chk_pin(pb_on, pb_en & {8{!sh[4][7]}});
      chk_pin(8'(an_o), 8'(sh[3][2:0] & ~{3{sh[8][4]}}));
      chk_pin(8'(mc_n), 8'(!sh[6][7] | !e3en | e3));
      // Capture inputs see the digital pin level only while the pin is an input
      k = exp_rd();
      chk_pin(8'(cap3), 8'(sh[2][0] & !sh[6][2] & k[0]));
      chk_pin(8'(cap5), 8'(sh[2][2] & k[2]));
      for (int i = 0; i < 9; i++) begin
        apb(AD[i], 1'h0, 8'h00);
        chk_reg(r, {24'h0, i == 0 ? exp_rd() : sh[i]});
      end
    end
    end_of_test();
  end
endmodule
